// ===== logic/shpm_pin_mux.sv
/*
 Pin function multiplexer with startup strap capture for the sensor hub.
 Assumes pad cells resolve the pins from out/oe; pin inputs are asynchronous,
 peripheral signals come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "shpm_consts.svh"
module shpm_pin_mux
    import shpm_pkg::*;
#(
    parameter int NUM_PINS = `SHPM_NUM_PINS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe,
    output logic [NUM_PINS-1:0] pin_pullup,
    input wire logic reset_pin_n_in,
    output logic reset_pin_n_out,
    output logic reset_pin_n_oe,
    input wire logic reset_out_req,
    input wire logic sel_write,
    input wire logic [3:0] sel_index,
    input wire logic [1:0] sel_value,
    output logic [NUM_PINS*2-1:0] sel_state,
    input wire logic [NUM_PINS-1:0] fast_gpio_port_out,
    input wire logic [NUM_PINS-1:0] fast_gpio_port_oe,
    input wire logic [NUM_PINS-1:0] fast_gpio_port_pullup,
    output logic [NUM_PINS-1:0] fast_gpio_port_in,
    output logic slave_serial_clock,
    output logic slave_serial_data_in,
    input wire logic slave_serial_data_oe,
    output logic spi_clock,
    output logic spi_data_in,
    input wire logic spi_data_out,
    input wire logic spi_data_out_oe,
    output logic spi_slave_select,
    output logic master_serial_clock_in,
    input wire logic master_serial_clock_oe,
    output logic master_serial_data_in,
    input wire logic master_serial_data_oe,
    output logic ext_interrupt,
    input wire logic delay_output_a,
    input wire logic delay_output_b,
    input wire logic command_complete_flag,
    output logic analog_input_neg_en,
    output logic analog_input_pos_en,
    input wire logic timer_channel_zero_out,
    input wire logic timer_channel_zero_oe,
    output logic timer_channel_zero_in,
    input wire logic timer_channel_one_out,
    input wire logic timer_channel_one_oe,
    output logic timer_channel_one_in,
    output logic debug_pin_in,
    input wire logic debug_pin_out,
    input wire logic debug_pin_oe,
    output logic straps_valid,
    output logic slave_spi_mode,
    output logic background_debug_mode,
    output logic boot_from_rom,
    output logic sys_reset_req
);
    shpm_state_t state;
    shpm_state_t next_state;
    logic [NUM_PINS-1:0] pin_meta;
    logic [NUM_PINS-1:0] pin_sync;
    logic rst_meta;
    logic rst_sync;
    logic [NUM_PINS-1:0] mode_first;
    logic [NUM_PINS-1:0] mode_second;
    logic [NUM_PINS-1:0] mode_third;
    logic [NUM_PINS-1:0] mode_gpio;

    // Pins with only two functions; their third code is unused
    function automatic logic has_third(input int pin);
        has_third = !(pin == `SHPM_PIN_INT || pin == `SHPM_PIN_G8 || pin == `SHPM_PIN_DBG);
    endfunction

    // Pins whose gpio line is the second function rather than the first
    function automatic logic gpio_second(input int pin);
        gpio_second = (pin == `SHPM_PIN_SCLK || pin == `SHPM_PIN_SDAT || pin == `SHPM_PIN_DBG);
    endfunction

    // Unused codes treated as primary so a stray write never leaves a pin undriven
    function automatic shpm_fn_t decode_sel(input logic [1:0] code, input logic third_ok);
        case (code)
            `SHPM_SEL_SECOND: decode_sel = shpm_fn_second;
            `SHPM_SEL_THIRD: decode_sel = third_ok ? shpm_fn_third : shpm_fn_first;
            default: decode_sel = shpm_fn_first;
        endcase
    endfunction

    // Two-stage synchronisers for all pad inputs
    // No reset: they keep sampling through reset so straps are settled at release
    always_ff @(posedge clock) begin
        pin_meta <= pin_in;
        pin_sync <= pin_meta;
        rst_meta <= reset_pin_n_in;
        rst_sync <= rst_meta;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_dec
            shpm_fn_t fn;
            assign fn = decode_sel(state.sel[gi*2 +: 2], has_third(gi));
            assign mode_first[gi] = (fn == shpm_fn_first);
            assign mode_second[gi] = (fn == shpm_fn_second);
            assign mode_third[gi] = (fn == shpm_fn_third);
            assign mode_gpio[gi] = gpio_second(gi) ? mode_second[gi] : mode_first[gi];
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_state.gpio_in = pin_sync;
        // Straps caught at the first edge after release; needs reset held two cycles
        unique case (state.phase)
            shpm_st_sample: begin
                next_state.spi_mode = ~pin_sync[`SHPM_PIN_MDAT];
                next_state.debug_mode = ~pin_sync[`SHPM_PIN_DBG];
                next_state.boot_rom = ~rst_sync;
                next_state.phase = shpm_st_run;
            end
            shpm_st_run: begin
                if (sel_write && (int'(sel_index) < NUM_PINS)) begin
                    next_state.sel[sel_index*2 +: 2] = sel_value;
                end
            end
        endcase
        // Reset pin drive is a short pulse so the pad cannot latch itself low
        if (reset_out_req && state.phase == shpm_st_run && state.rst_drive_cnt == 4'h0) begin
            next_state.rst_drive_cnt = `SHPM_RESET_PULSE;
        end else if (state.rst_drive_cnt != 4'h0) begin
            next_state.rst_drive_cnt = state.rst_drive_cnt - 4'h1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state.phase <= shpm_st_sample;
            state.sel <= '0;
            state.spi_mode <= 1'b0;
            state.debug_mode <= 1'b0;
            state.boot_rom <= 1'b0;
            state.rst_drive_cnt <= 4'h0;
            state.gpio_in <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sel_state = state.sel;
    assign straps_valid = (state.phase == shpm_st_run);
    assign slave_spi_mode = state.spi_mode;
    assign background_debug_mode = state.debug_mode;
    assign boot_from_rom = state.boot_rom;
    assign reset_pin_n_out = 1'b0;
    assign reset_pin_n_oe = (state.rst_drive_cnt != 4'h0);
    // External low on the reset pin after startup resets the system
    assign sys_reset_req = straps_valid && !rst_sync;

    // Slave port and other peripheral input paths are pure routing, no cpu involvement
    assign slave_serial_clock = mode_first[`SHPM_PIN_SCLK] & state.gpio_in[`SHPM_PIN_SCLK];
    assign spi_clock = mode_third[`SHPM_PIN_SCLK] & state.gpio_in[`SHPM_PIN_SCLK];
    assign slave_serial_data_in = mode_first[`SHPM_PIN_SDAT] & state.gpio_in[`SHPM_PIN_SDAT];
    assign spi_data_in = mode_third[`SHPM_PIN_SDAT] & state.gpio_in[`SHPM_PIN_SDAT];
    assign master_serial_clock_in = mode_second[`SHPM_PIN_MCLK] & state.gpio_in[`SHPM_PIN_MCLK];
    assign master_serial_data_in = mode_second[`SHPM_PIN_MDAT] & state.gpio_in[`SHPM_PIN_MDAT];
    // Idle high so a deselected select never looks active
    assign spi_slave_select = ~mode_third[`SHPM_PIN_MDAT] | state.gpio_in[`SHPM_PIN_MDAT];
    assign ext_interrupt = mode_second[`SHPM_PIN_INT] & state.gpio_in[`SHPM_PIN_INT];
    assign analog_input_neg_en = mode_second[`SHPM_PIN_G6];
    assign analog_input_pos_en = mode_second[`SHPM_PIN_G7];
    assign timer_channel_zero_in = mode_third[`SHPM_PIN_G6] & state.gpio_in[`SHPM_PIN_G6];
    assign timer_channel_one_in = mode_third[`SHPM_PIN_G7] & state.gpio_in[`SHPM_PIN_G7];
    assign debug_pin_in = mode_first[`SHPM_PIN_DBG] & state.gpio_in[`SHPM_PIN_DBG];

    // Per-pin output drive: exactly one function owns each pad
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            fast_gpio_port_in[i] = 1'b0;
            pin_out[i] = 1'b0;
            pin_oe[i] = 1'b0;
            pin_pullup[i] = 1'b0;
        end
        // Gpio function: first on pins 2..8, second on 0, 1 and 9
        for (int i = 0; i < NUM_PINS; i++) begin
            if (mode_gpio[i]) begin
                fast_gpio_port_in[i] = state.gpio_in[i];
                pin_out[i] = fast_gpio_port_out[i];
                pin_oe[i] = fast_gpio_port_oe[i];
                pin_pullup[i] = fast_gpio_port_pullup[i];
            end
        end
        // Slave and master serial buses are open drain: drive low only
        if (mode_first[`SHPM_PIN_SDAT]) begin
            pin_oe[`SHPM_PIN_SDAT] = slave_serial_data_oe;
        end
        if (mode_third[`SHPM_PIN_SDAT]) begin
            pin_oe[`SHPM_PIN_SDAT] = 1'b0;
        end
        if (mode_second[`SHPM_PIN_MCLK]) begin
            pin_oe[`SHPM_PIN_MCLK] = master_serial_clock_oe;
        end
        if (mode_third[`SHPM_PIN_MCLK]) begin
            pin_out[`SHPM_PIN_MCLK] = spi_data_out;
            pin_oe[`SHPM_PIN_MCLK] = spi_data_out_oe;
        end
        if (mode_second[`SHPM_PIN_MDAT]) begin
            pin_oe[`SHPM_PIN_MDAT] = master_serial_data_oe;
        end
        if (mode_second[`SHPM_PIN_G5]) begin
            pin_out[`SHPM_PIN_G5] = delay_output_a;
            pin_oe[`SHPM_PIN_G5] = 1'b1;
        end
        if (mode_third[`SHPM_PIN_G5]) begin
            pin_out[`SHPM_PIN_G5] = command_complete_flag;
            pin_oe[`SHPM_PIN_G5] = 1'b1;
        end
        if (mode_third[`SHPM_PIN_G6]) begin
            pin_out[`SHPM_PIN_G6] = timer_channel_zero_out;
            pin_oe[`SHPM_PIN_G6] = timer_channel_zero_oe;
        end
        if (mode_third[`SHPM_PIN_G7]) begin
            pin_out[`SHPM_PIN_G7] = timer_channel_one_out;
            pin_oe[`SHPM_PIN_G7] = timer_channel_one_oe;
        end
        if (mode_second[`SHPM_PIN_G8]) begin
            pin_out[`SHPM_PIN_G8] = delay_output_b;
            pin_oe[`SHPM_PIN_G8] = 1'b1;
        end
        if (mode_first[`SHPM_PIN_DBG]) begin
            pin_out[`SHPM_PIN_DBG] = debug_pin_out;
            pin_oe[`SHPM_PIN_DBG] = debug_pin_oe & state.debug_mode;
            pin_pullup[`SHPM_PIN_DBG] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== shared/shpm_consts.svh
/*
 Constants for the sensor hub pin multiplexer: selector codes, pin indices.
 Assumes inclusion by the package and the design file only.
*/
`ifndef SHPM_CONSTS_SVH
`define SHPM_CONSTS_SVH
`define SHPM_NUM_PINS 10
`define SHPM_SEL_W 2
`define SHPM_SEL_PRIMARY 2'h0
`define SHPM_SEL_SECOND 2'h1
`define SHPM_SEL_THIRD 2'h2
`define SHPM_PIN_SCLK 0
`define SHPM_PIN_SDAT 1
`define SHPM_PIN_MCLK 2
`define SHPM_PIN_MDAT 3
`define SHPM_PIN_INT 4
`define SHPM_PIN_G5 5
`define SHPM_PIN_G6 6
`define SHPM_PIN_G7 7
`define SHPM_PIN_G8 8
`define SHPM_PIN_DBG 9
`define SHPM_RESET_PULSE 4'h8
`endif

// ===== shared/shpm_pkg.sv
/*
 Types for the sensor hub pin multiplexer.
 Assumes the constants header is on the include path.
*/
`include "shpm_consts.svh"
package shpm_pkg;
    typedef enum logic [1:0] {
        shpm_fn_first,
        shpm_fn_second,
        shpm_fn_third
    } shpm_fn_t;

    typedef enum {
        shpm_st_sample,
        shpm_st_run
    } shpm_phase_t;

    typedef struct packed {
        shpm_phase_t phase;
        logic [`SHPM_NUM_PINS*`SHPM_SEL_W-1:0] sel;
        logic spi_mode;
        logic debug_mode;
        logic boot_rom;
        logic [3:0] rst_drive_cnt;
        logic [`SHPM_NUM_PINS-1:0] gpio_in;
    } shpm_state_t;
endpackage

// ===== testbench/shpm_pads.sv
/*
 Board and host model of the ten shared pads and the reset pad.
 Assumes the bench sets host drive levels; pads are wired-and.
*/
`timescale 1ns/1ps
`default_nettype none
module shpm_pads (
    input wire logic clock,
    input wire logic [9:0] pin_out,
    input wire logic [9:0] pin_oe,
    input wire logic [9:0] pin_pullup,
    input wire logic [9:0] host_lvl,
    input wire logic [9:0] host_oe,
    input wire logic reset_pin_n_out,
    input wire logic reset_pin_n_oe,
    input wire logic host_rst_low,
    output logic [9:0] pin_in,
    output logic reset_pin_n_in
);
    // Bus pull-up resistors on the board
    localparam logic [9:0] BOARD_PU = 10'h00e;
    logic [9:0] last = 10'h000;
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (pin_oe[i] || host_oe[i])
                pin_in[i] = (pin_out[i] | !pin_oe[i]) & (host_lvl[i] | !host_oe[i]);
            else if (pin_pullup[i] || BOARD_PU[i])
                pin_in[i] = 1'h1;
            else
                pin_in[i] = ~last[i]; // Floating pad has no value to trust
        end
    end
    always @(posedge clock) last <= pin_in;
    // Weak pull-up; either side may pull low
    assign reset_pin_n_in = !(host_rst_low || (reset_pin_n_oe && !reset_pin_n_out));
endmodule
`default_nettype wire

// ===== testbench/shpm_props.sv
/*
 Port assertions for the sensor hub pin multiplexer.
 Assumes a bind to shpm_pin_mux; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module shpm_props #(
    parameter int NUM_PINS = 10
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [NUM_PINS*2-1:0] sel_state,
    input wire logic sel_write,
    input wire logic [3:0] sel_index,
    input wire logic [1:0] sel_value,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe,
    input wire logic command_complete_flag,
    input wire logic spi_data_out,
    input wire logic spi_data_out_oe,
    input wire logic reset_out_req,
    input wire logic reset_pin_n_out,
    input wire logic reset_pin_n_oe,
    input wire logic straps_valid,
    input wire logic slave_spi_mode,
    input wire logic background_debug_mode,
    input wire logic boot_from_rom
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sel_reset_a: assert property ($fell(reset) |-> sel_state == '0)
        else $error("selectors not primary after reset");
    sel_write_a: assert property (sel_write && straps_valid && sel_index < 4'ha
        |=> sel_state[{$past(sel_index), 1'h0} +: 2] == $past(sel_value)) else $error("write lost");
    sel_hold_a: assert property (!(sel_write && straps_valid && sel_index < 4'ha)
        |=> $stable(sel_state)) else $error("selectors changed without write");
    int_only_a: assert property (sel_state[11:10] == 2'h2
        |-> pin_oe[5] && pin_out[5] == command_complete_flag) else $error("pad 5 not flag");
    spi_out_a: assert property (sel_state[5:4] == 2'h2
        |-> pin_oe[2] == spi_data_out_oe && pin_out[2] == spi_data_out) else $error("pad 2");
    rst_pulse_a: assert property ($rose(reset_pin_n_oe)
        |-> reset_pin_n_oe [*8] ##1 !reset_pin_n_oe) else $error("reset pulse length");
    rst_take_a: assert property (reset_out_req && straps_valid && !reset_pin_n_oe
        |=> reset_pin_n_oe) else $error("reset request ignored");
    rst_low_a: assert property (reset_pin_n_oe |-> !reset_pin_n_out)
        else $error("reset pad driven high");
    strap_time_a: assert property ($fell(reset) |=> straps_valid)
        else $error("straps late");
    strap_hold_a: assert property (straps_valid && $past(straps_valid)
        |-> $stable({slave_spi_mode, background_debug_mode, boot_from_rom}))
        else $error("straps changed");
endmodule
bind shpm_pin_mux shpm_props #(.NUM_PINS(NUM_PINS)) shpm_props_i (.*);
`default_nettype wire

// ===== testbench/tb_top.sv
/*
 Self-checking bench for the pin multiplexer.
 Assumes the pad model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock = 1'h0, reset = 1'h1, reset_out_req = 1'h0, sel_write = 1'h0, host_rst_low = 1'h0;
    logic [3:0] sel_index = 4'h0;
    logic [1:0] sel_value = 2'h0;
    logic [9:0] host_lvl = 10'h3f7, host_oe = 10'h3ff, fast_gpio_port_out = 10'h000,
        fast_gpio_port_oe = 10'h000, fast_gpio_port_pullup = 10'h000;
    logic slave_serial_data_oe = 1'h0, spi_data_out = 1'h0, spi_data_out_oe = 1'h0,
        master_serial_clock_oe = 1'h0, master_serial_data_oe = 1'h0, delay_output_a = 1'h0,
        delay_output_b = 1'h0, command_complete_flag = 1'h1, timer_channel_zero_out = 1'h0,
        timer_channel_zero_oe = 1'h0, timer_channel_one_out = 1'h0, timer_channel_one_oe = 1'h0,
        debug_pin_out = 1'h0, debug_pin_oe = 1'h1;
    logic [9:0] pin_in, pin_out, pin_oe, pin_pullup, fast_gpio_port_in;
    logic [19:0] sel_state;
    logic reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe, slave_serial_clock, slave_serial_data_in,
        spi_clock, spi_data_in, spi_slave_select, master_serial_clock_in, master_serial_data_in,
        ext_interrupt, analog_input_neg_en, analog_input_pos_en, timer_channel_zero_in,
        timer_channel_one_in, debug_pin_in, straps_valid, slave_spi_mode, background_debug_mode,
        boot_from_rom, sys_reset_req;
    int n_fail = 0, compares = 0;
    shpm_pin_mux shpm_pin_mux_i (.*);
    shpm_pads shpm_pads_i (.*);
    always #10 clock = ~clock;
    task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Leaves the strobe up so back-to-back writes never retoggle it
    task automatic wr(input logic [3:0] i, input logic [1:0] v);
        sel_index = i;
        sel_value = v;
        sel_write = 1'h1;
        tick(1);
    endtask
    task automatic results();
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_straps(input logic ssel, input logic dbg, input logic rlow);
        host_lvl[3] = ssel;
        host_lvl[9] = dbg;
        host_rst_low = rlow;
        reset = 1'h1;
        tick(8);
        reset = 1'h0;
        tick(2);
        chk("spi", !ssel, slave_spi_mode);
        chk("debug", !dbg, background_debug_mode);
        chk("debug oe", !dbg, pin_oe[9]);
        chk("rom", rlow, boot_from_rom);
        chk("sel", 20'h0, sel_state);
        chk("pullup", 10'h200, pin_pullup);
        chk("gpio oe", 10'h000, pin_oe[8:0]);
        host_rst_low = 1'h0;
        tick(4);
    endtask
    task automatic t_sel();
        logic [19:0] e = 20'h0;
        for (int i = 0; i < 10; i++) begin
            for (int v = 1; v < 5; v++) begin
                wr(i[3:0], v[1:0]);
                e[2*i +: 2] = v[1:0];
                chk("sel", e, sel_state);
            end
        end
        wr(4'ha, 2'h1);
        wr(4'hf, 2'h2);
        sel_write = 1'h0;
        chk("sel refused", 20'h0, sel_state);
    endtask
    task automatic t_pin5();
        for (int f = 0; f < 2; f++) begin
            command_complete_flag = f[0];
            delay_output_a = !f[0];
            for (int v = 0; v < 4; v++) begin
                wr(4'h5, v[1:0]);
                chk("pad5", {v == 1 || v == 2, (v == 1 && !f[0]) || (v == 2 && f[0])},
                    {pin_oe[5], pin_out[5] & pin_oe[5]});
            end
        end
        sel_write = 1'h0;
    endtask
    // Run at both pad levels so a function that ignores its pad is caught
    task automatic t_route2(input logic lvl);
        logic p, s, t;
        host_lvl = lvl ? 10'h3ff : 10'h000;
        debug_pin_oe = 1'h0;
        delay_output_b = 1'h1;
        for (int v = 0; v < 4; v++) begin
            p = (v == 0 || v == 3);
            s = (v == 1);
            t = (v == 2);
            wr(4'h1, v[1:0]);
            wr(4'h3, v[1:0]);
            wr(4'h4, v[1:0]);
            wr(4'h7, v[1:0]);
            wr(4'h8, v[1:0]);
            wr(4'h9, v[1:0]);
            sel_write = 1'h0;
            tick(3);
            chk("pad1", {p & lvl, s & lvl, t & lvl},
                {slave_serial_data_in, fast_gpio_port_in[1], spi_data_in});
            chk("pad3", {p & lvl, s & lvl, !t | lvl},
                {fast_gpio_port_in[3], master_serial_data_in, spi_slave_select});
            chk("pad4", {!s & lvl, s & lvl}, {fast_gpio_port_in[4], ext_interrupt});
            chk("pad7", {p & lvl, s, t & lvl},
                {fast_gpio_port_in[7], analog_input_pos_en, timer_channel_one_in});
            chk("pad8", {!s & lvl, s, s}, {fast_gpio_port_in[8], pin_oe[8], pin_out[8]});
            chk("pad9", {!s & lvl, s & lvl, !s},
                {debug_pin_in, fast_gpio_port_in[9], pin_pullup[9]});
        end
    endtask
    task automatic t_route();
        for (int v = 0; v < 4; v++) begin
            wr(4'h0, v[1:0]);
            wr(4'h6, v[1:0]);
            sel_write = 1'h0;
            tick(3);
            chk("pad0", {v == 0 || v == 3, v == 1, v == 2},
                {slave_serial_clock, fast_gpio_port_in[0], spi_clock});
            chk("pad6", {v == 0 || v == 3, v == 1, v == 2},
                {fast_gpio_port_in[6], analog_input_neg_en, timer_channel_zero_in});
        end
    endtask
    task automatic t_rst();
        int n = 0;
        logic seen = 1'h0;
        reset_out_req = 1'h1;
        tick(1);
        while (reset_pin_n_oe === 1'h1 && n < 20) begin
            n++;
            if (n == 2)
                reset_out_req = 1'h0;
            seen |= sys_reset_req;
            tick(1);
        end
        chk("pulse", 20'd8, n[19:0]);
        chk("sys reset", 1'h1, seen);
        tick(4);
        chk("sys reset end", 1'h0, sys_reset_req);
    endtask
    initial begin
        t_straps(1'h0, 1'h1, 1'h0);
        t_straps(1'h1, 1'h0, 1'h1);
        t_sel();
        t_pin5();
        t_route();
        t_route2(1'h1);
        t_route2(1'h0);
        t_rst();
        results();
    end
    initial begin
        #200000;
        n_fail++;
        results();
    end
endmodule
`default_nettype wire
